/* src/boost_seq_defines.svh */
// Timing and encoding constants for the boost mode sequencer
`ifndef BOOST_SEQ_DEFINES_SVH
`define BOOST_SEQ_DEFINES_SVH
`define CLK_FREQ_KHZ 20000
`define SHUTDOWN_LOW_US 500
`define SHUTDOWN_LOW_CYC ((`SHUTDOWN_LOW_US * `CLK_FREQ_KHZ + 999) / 1000)
`define PSM_WINDOW_US 32
`define PSM_WINDOW_CYC ((`PSM_WINDOW_US * `CLK_FREQ_KHZ) / 1000)
`define FB_DETECT_US 20
`define FB_DETECT_CYC ((`FB_DETECT_US * `CLK_FREQ_KHZ) / 1000)
`define SW_RUN_KHZ 2000
`define SW_SS_KHZ 500
`define SW_RUN_DIV (`CLK_FREQ_KHZ / `SW_RUN_KHZ)
`define SW_SS_DIV (`CLK_FREQ_KHZ / `SW_SS_KHZ)
`define LIM_SS 2'h1
`endif

/* src/boost_seq_pkg.sv */
// Types shared by the boost mode sequencer modules
package boost_seq_pkg;
    typedef enum logic [1:0] {
        LIM_NONE = 2'h0,
        LIM_ONE = 2'h1,
        LIM_TWO = 2'h2,
        LIM_THREE = 2'h3
    } limit_level_t;

    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_FB_DETECT = 3'h1,
        ST_LINEAR = 3'h2,
        ST_SOFT = 3'h3,
        ST_PWM = 3'h4,
        ST_BURST = 3'h5,
        ST_SAVE = 3'h6
    } op_state_t;
endpackage

/* src/pulse_if.sv */
// Carrier between the enable pulse decoder and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface pulse_if;
    logic enabled;
    logic shutdown;
    boost_seq_pkg::limit_level_t level;
    modport decoder (output enabled, output shutdown, output level);
    modport sequencer (input enabled, input shutdown, input level);
endinterface
`default_nettype wire

/* src/enable_pulse_decoder.sv */
// Enable pin synchroniser, edge counter and shutdown timer
`timescale 1ns/1ps
`default_nettype none
`include "boost_seq_defines.svh"
module enable_pulse_decoder #(
    parameter int SHUTDOWN_CYC = `SHUTDOWN_LOW_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic enable_pin,
    pulse_if.decoder pi
);
    localparam int CW = $clog2(SHUTDOWN_CYC + 1);
    logic [2:0] sync_q, sync_d;
    logic en_q, en_d;
    logic [CW-1:0] low_cnt_q, low_cnt_d;
    logic off_q, off_d;
    boost_seq_pkg::limit_level_t lvl_q, lvl_d;
    logic rise;

    always_comb begin
        sync_d = {sync_q[1:0], enable_pin};
        en_d = en_q;
        // Filtered level changes only once the second and third stage agree
        if (sync_q[2] == sync_q[1]) begin
            en_d = sync_q[2];
        end
        rise = en_d && !en_q;
        low_cnt_d = low_cnt_q;
        off_d = off_q;
        lvl_d = lvl_q;
        if (en_d) begin
            low_cnt_d = '0;
            off_d = 1'b0;
        end else if (low_cnt_q < CW'(SHUTDOWN_CYC)) begin
            low_cnt_d = low_cnt_q + CW'(1);
        end else begin
            off_d = 1'b1;
            lvl_d = boost_seq_pkg::LIM_NONE;
        end
        if (rise) begin
            // Level three wraps through an idle step, so two pulses reach one
            case (lvl_q)
                boost_seq_pkg::LIM_NONE: lvl_d = boost_seq_pkg::LIM_ONE;
                boost_seq_pkg::LIM_ONE: lvl_d = boost_seq_pkg::LIM_TWO;
                boost_seq_pkg::LIM_TWO: lvl_d = boost_seq_pkg::LIM_THREE;
                boost_seq_pkg::LIM_THREE: lvl_d = boost_seq_pkg::LIM_NONE;
                default: lvl_d = boost_seq_pkg::LIM_NONE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_q <= 3'h0;
            en_q <= 1'b0;
            low_cnt_q <= '0;
            off_q <= 1'b1;
            lvl_q <= boost_seq_pkg::LIM_NONE;
        end else begin
            sync_q <= sync_d;
            en_q <= en_d;
            low_cnt_q <= low_cnt_d;
            off_q <= off_d;
            lvl_q <= lvl_d;
        end
    end

    assign pi.enabled = en_q;
    assign pi.shutdown = off_q;
    assign pi.level = lvl_q;

    AST_SHUTDOWN_CLEARS: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(off_q) |-> lvl_q == boost_seq_pkg::LIM_NONE)
        else $error("level not cleared at shutdown");
    AST_LEVEL_ADVANCE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        rise && lvl_q == boost_seq_pkg::LIM_ONE |=> lvl_q == boost_seq_pkg::LIM_TWO)
        else $error("level one did not advance to two");
endmodule
`default_nettype wire

/* src/boost_mode_sequencer.sv */
// Digital sequencer of a synchronous boost regulator
// Notes on behaviour
// - first enable pulse after power-up selects limit level one, 0.75 A.
// - at level one, one pulse moves to level two, 1.9 A.
// - at level two, one pulse moves to level three, 2.7 A.
// - at level three, two pulses return to level one.
// - limit level follows the count of enable rising edges.
// - enable held high without pulses uses the minimum limit level.
// - enable low for 500 us or longer forces shutdown.
// - light load enters burst; heavier load returns to fixed-rate PWM.
// - burst stops switching at target, resumes on droop, keeps 2 MHz.
// - burst output not drooping within 32 us enters power save.
// - power save disables circuits until output falls below save threshold.
// - PWM turns low switch on each 2 MHz tick, off at loop current.
// - peak current at selected limit turns switch off until next cycle.
// - start-up charges output linearly; switching starts near input voltage.
// - soft start switches at 500 kHz with 750 mA limit.
// - first power-on after reset runs 20 us feedback probe; high pin selects external divider.
// - feedback pin low through probe selects internal fixed 5 V divider.
// - undervoltage stops operation; resumes after hysteresis clears.
`timescale 1ns/1ps
`default_nettype none
`include "boost_seq_defines.svh"
module boost_mode_sequencer #(
    parameter int SHUTDOWN_CYC = `SHUTDOWN_LOW_CYC,
    parameter int PSM_CYC = `PSM_WINDOW_CYC,
    parameter int FB_CYC = `FB_DETECT_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic enable_pin,
    input wire logic feedback_sense_pin,
    input wire logic vin_ok,
    input wire logic vout_near_vin,
    input wire logic vout_at_target,
    input wire logic vout_below_save,
    input wire logic light_load,
    input wire logic loop_current_trip,
    input wire logic peak_limit_trip,
    output logic switch_node,
    output logic fb_source_en,
    output logic ext_divider,
    output logic linear_charge,
    output logic bias_en,
    output logic [1:0] limit_sel,
    output logic [2:0] op_state
);
    localparam int DW = $clog2(`SW_SS_DIV + 1);
    localparam int TW = $clog2((PSM_CYC > FB_CYC ? PSM_CYC : FB_CYC) + 1);

    pulse_if pi ();
    logic fb_high;
    logic vin_s;

    enable_pulse_decoder #(.SHUTDOWN_CYC(SHUTDOWN_CYC)) u_dec (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .enable_pin(enable_pin),
        .pi(pi)
    );

    sync3 #(.W(2)) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .din({feedback_sense_pin, vin_ok}),
        .dout({fb_high, vin_s})
    );

    boost_seq_pkg::op_state_t st_q, st_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic [DW-1:0] div_q, div_d;
    logic sw_q, sw_d;
    logic ext_q, ext_d;
    logic probed_q, probed_d;
    logic [1:0] lim_q, lim_d;
    logic tick;
    logic [DW-1:0] div_top;

    // UVLO hysteresis lives in the analog comparator; vin_ok already carries it
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        ext_d = ext_q;
        probed_d = probed_q;
        case (st_q)
            boost_seq_pkg::ST_OFF: begin
                tmr_d = '0;
                if (!probed_q && vin_s) begin
                    st_d = boost_seq_pkg::ST_FB_DETECT;
                end else if (vin_s && pi.enabled && !pi.shutdown) begin
                    st_d = boost_seq_pkg::ST_LINEAR;
                end
            end
            boost_seq_pkg::ST_FB_DETECT: begin
                tmr_d = tmr_q + TW'(1);
                if (fb_high) begin
                    ext_d = 1'b1;
                    probed_d = 1'b1;
                    st_d = boost_seq_pkg::ST_OFF;
                end else if (tmr_q >= TW'(FB_CYC - 1)) begin
                    ext_d = 1'b0;
                    probed_d = 1'b1;
                    st_d = boost_seq_pkg::ST_OFF;
                end
            end
            boost_seq_pkg::ST_LINEAR: begin
                if (vout_near_vin) begin
                    st_d = boost_seq_pkg::ST_SOFT;
                end
            end
            boost_seq_pkg::ST_SOFT: begin
                if (vout_at_target) begin
                    st_d = boost_seq_pkg::ST_PWM;
                end
            end
            boost_seq_pkg::ST_PWM: begin
                tmr_d = '0;
                if (light_load) begin
                    st_d = boost_seq_pkg::ST_BURST;
                end
            end
            boost_seq_pkg::ST_BURST: begin
                if (!light_load) begin
                    st_d = boost_seq_pkg::ST_PWM;
                end else if (vout_below_save) begin
                    tmr_d = '0;
                end else if (tmr_q >= TW'(PSM_CYC - 1)) begin
                    st_d = boost_seq_pkg::ST_SAVE;
                end else begin
                    tmr_d = tmr_q + TW'(1);
                end
            end
            boost_seq_pkg::ST_SAVE: begin
                tmr_d = '0;
                if (vout_below_save) begin
                    st_d = boost_seq_pkg::ST_BURST;
                end
            end
            default: st_d = boost_seq_pkg::ST_OFF;
        endcase
        // Undervoltage and shutdown override every running state
        if (st_q != boost_seq_pkg::ST_FB_DETECT && st_q != boost_seq_pkg::ST_OFF) begin
            if (!vin_s || pi.shutdown) begin
                st_d = boost_seq_pkg::ST_OFF;
            end
        end
        if (!vin_s) begin
            probed_d = probed_q && st_q != boost_seq_pkg::ST_FB_DETECT;
        end
    end

    // Switching tick: 2 MHz in run states, 500 kHz during soft start
    always_comb begin
        div_top = (st_q == boost_seq_pkg::ST_SOFT) ? DW'(`SW_SS_DIV - 1)
                                                  : DW'(`SW_RUN_DIV - 1);
        tick = (div_q >= div_top);
        div_d = tick ? '0 : div_q + DW'(1);
        sw_d = sw_q;
        if (tick) begin
            sw_d = 1'b1;
        end
        if (peak_limit_trip || loop_current_trip) begin
            sw_d = 1'b0;
        end
        case (st_q)
            boost_seq_pkg::ST_SOFT, boost_seq_pkg::ST_PWM: ;
            boost_seq_pkg::ST_BURST: if (vout_at_target) sw_d = 1'b0;
            default: sw_d = 1'b0;
        endcase
    end

    // Limit group: soft start overrides the level picked by enable pulses
    always_comb begin
        // Level none follows the wrap after level three, since enable tied high still counts one rising edge
        lim_d = (pi.level == boost_seq_pkg::LIM_NONE) ? 2'(boost_seq_pkg::LIM_ONE)
                                                      : 2'(pi.level);
        if (st_q == boost_seq_pkg::ST_SOFT) begin
            lim_d = `LIM_SS;
        end
    end

    // Reset value is the soft start limit, the safest level before any pulse
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lim_q <= `LIM_SS;
        end else begin
            lim_q <= lim_d;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= boost_seq_pkg::ST_OFF;
            tmr_q <= '0;
            div_q <= '0;
            sw_q <= 1'b0;
            ext_q <= 1'b0;
            probed_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            div_q <= div_d;
            sw_q <= sw_d;
            ext_q <= ext_d;
            probed_q <= probed_d;
        end
    end

    assign switch_node = sw_q;
    assign fb_source_en = (st_q == boost_seq_pkg::ST_FB_DETECT);
    assign ext_divider = ext_q;
    assign linear_charge = (st_q == boost_seq_pkg::ST_LINEAR);
    assign bias_en = (st_q != boost_seq_pkg::ST_SAVE) && (st_q != boost_seq_pkg::ST_OFF);
    assign limit_sel = lim_q;
    assign op_state = 3'(st_q);

    AST_PEAK_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
        peak_limit_trip |=> !sw_q)
        else $error("switch stayed on past peak limit");
    AST_SOFT_LIMIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_SOFT |=> lim_q == `LIM_SS)
        else $error("soft start limit wrong");
    AST_FB_INTERNAL: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(fb_source_en) ##1 (!fb_high) [*3] |-> ##[0:400] !fb_source_en)
        else $error("feedback probe did not end");
    AST_SAVE_ENTRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_SAVE && $past(st_q) != boost_seq_pkg::ST_SAVE
        |-> $past(st_q) == boost_seq_pkg::ST_BURST && $past(tmr_q) == TW'(PSM_CYC - 1))
        else $error("power save entered without full window");
    AST_UVLO_STOP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !vin_s && st_q == boost_seq_pkg::ST_PWM |=> st_q == boost_seq_pkg::ST_OFF)
        else $error("undervoltage did not stop operation");
    AST_BURST_TARGET: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_BURST && vout_at_target |=> !sw_q)
        else $error("burst switched at target");
    AST_SW_ON_TICK: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(sw_q) |-> $past(tick))
        else $error("switch turned on off tick");
    // Transition checks only hold while supply and enable keep the converter running
    AST_FB_EXTERNAL: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_FB_DETECT && fb_high |=> st_q == boost_seq_pkg::ST_OFF && ext_q)
        else $error("external divider not selected");
    AST_PROBE_ONCE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_OFF && probed_q |=> st_q != boost_seq_pkg::ST_FB_DETECT)
        else $error("feedback probe repeated without reset");
    AST_ENABLE_START: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_OFF && probed_q && vin_s && pi.enabled && !pi.shutdown
        |=> st_q == boost_seq_pkg::ST_LINEAR)
        else $error("start-up did not begin with linear charge");
    AST_LINEAR_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_LINEAR && !vout_near_vin && vin_s && !pi.shutdown
        |=> st_q == boost_seq_pkg::ST_LINEAR)
        else $error("switching began below input voltage");
    AST_LINEAR_NO_SW: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_LINEAR |=> !sw_q)
        else $error("switch active during linear charge");
    AST_SOFT_TICK: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(sw_q) && st_q == boost_seq_pkg::ST_SOFT |-> $past(div_q) >= DW'(`SW_SS_DIV - 1))
        else $error("soft start switched faster than its rate");
    AST_PWM_TICK: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(sw_q) && st_q == boost_seq_pkg::ST_PWM && $past(st_q) == boost_seq_pkg::ST_PWM
        |-> $past(div_q) >= DW'(`SW_RUN_DIV - 1))
        else $error("pwm switched off its tick");
    AST_LOOP_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
        loop_current_trip |=> !sw_q)
        else $error("switch stayed on past loop current");
    AST_PWM_TO_BURST: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_PWM && light_load && vin_s && !pi.shutdown
        |=> st_q == boost_seq_pkg::ST_BURST)
        else $error("light load did not enter burst");
    AST_BURST_TO_PWM: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_BURST && !light_load && vin_s && !pi.shutdown
        |=> st_q == boost_seq_pkg::ST_PWM)
        else $error("load rise did not return to pwm");
    AST_BURST_RESUME: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_BURST && !vout_at_target && tick
        && !peak_limit_trip && !loop_current_trip |=> sw_q)
        else $error("burst did not resume on droop");
    AST_SAVE_EXIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_SAVE && vout_below_save && vin_s && !pi.shutdown
        |=> st_q == boost_seq_pkg::ST_BURST)
        else $error("power save did not resume");
    AST_SAVE_BIAS: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_SAVE |-> !bias_en)
        else $error("bias left on in power save");
    AST_SHUTDOWN_STOP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pi.shutdown && st_q == boost_seq_pkg::ST_PWM |=> st_q == boost_seq_pkg::ST_OFF)
        else $error("shutdown did not stop operation");
    AST_UVLO_BURST: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !vin_s && st_q == boost_seq_pkg::ST_BURST |=> st_q == boost_seq_pkg::ST_OFF)
        else $error("undervoltage did not stop burst");
    AST_MIN_LIMIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_PWM && pi.level == boost_seq_pkg::LIM_NONE
        |=> lim_q == 2'(boost_seq_pkg::LIM_ONE))
        else $error("missing level did not give minimum limit");
    AST_LEVEL_ONE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_PWM && pi.level == boost_seq_pkg::LIM_ONE
        |=> lim_q == 2'(boost_seq_pkg::LIM_ONE))
        else $error("level one limit wrong");
    AST_LEVEL_TWO: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_PWM && pi.level == boost_seq_pkg::LIM_TWO
        |=> lim_q == 2'(boost_seq_pkg::LIM_TWO))
        else $error("level two limit wrong");
    AST_LEVEL_THREE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == boost_seq_pkg::ST_PWM && pi.level == boost_seq_pkg::LIM_THREE
        |=> lim_q == 2'(boost_seq_pkg::LIM_THREE))
        else $error("level three limit wrong");
    COV_SOFT: cover property (@(posedge ref_clk) st_q == boost_seq_pkg::ST_SOFT);
    COV_INT: cover property (@(posedge ref_clk) $fell(fb_source_en) && !ext_q);
    COV_PWM: cover property (@(posedge ref_clk) st_q == boost_seq_pkg::ST_PWM);
    COV_SAVE: cover property (@(posedge ref_clk) st_q == boost_seq_pkg::ST_SAVE);
    COV_EXT: cover property (@(posedge ref_clk) $rose(ext_q));
endmodule
`default_nettype wire

/* src/sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // Stage one feeds only stage two
            always_comb begin
                out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
            end
        end
    endgenerate
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end
    assign dout = out_q;
endmodule
`default_nettype wire

/* verification/enable_host_model.sv */
// Host GPIO model that drives the enable pulse pin
`timescale 1ns/1ps
`default_nettype none
module enable_host_model #(
    parameter int MIN_CYC = 15,
    parameter int MAX_CYC = 200
) (
    input wire logic ref_clk,
    output logic enable_pin
);
    initial enable_pin = 1'b0;

    // Widths are clamped so the pulse task never leaves the legal phase window
    function automatic int clamp(input int c);
        return (c < MIN_CYC) ? MIN_CYC : ((c > MAX_CYC) ? MAX_CYC : c);
    endfunction

    task automatic pulse(input int hi, input int lo);
        @(posedge ref_clk);
        enable_pin <= 1'b1;
        repeat (clamp(hi)) @(posedge ref_clk);
        enable_pin <= 1'b0;
        repeat (clamp(lo)) @(posedge ref_clk);
    endtask

    task automatic hold_low(input int n);
        @(posedge ref_clk);
        enable_pin <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic hold_high();
        @(posedge ref_clk);
        enable_pin <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking testbench for the boost mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int SD = 50;
    localparam int PSM = 16;
    localparam int FB = 20;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic enable_pin;
    logic feedback_sense_pin = 1'b0;
    logic vin_ok = 1'b0;
    logic vout_near_vin = 1'b0;
    logic vout_at_target = 1'b0;
    logic vout_below_save = 1'b0;
    logic light_load = 1'b0;
    logic loop_current_trip = 1'b0;
    logic peak_limit_trip = 1'b0;
    logic switch_node;
    logic fb_source_en;
    logic ext_divider;
    logic linear_charge;
    logic bias_en;
    logic [1:0] limit_sel;
    logic [2:0] op_state;
    int num_errors = 0;
    int n_tests = 0;
    int n_pulses = 0;
    int r;
    int seed_v;
    int trip_kind = 0;

    always #25 ref_clk = ~ref_clk;

    // Current ramp model: the chosen comparator trips a cycle after the switch closes
    always @(posedge ref_clk) begin
        loop_current_trip <= (trip_kind == 1) && switch_node;
        peak_limit_trip <= (trip_kind == 2) && switch_node;
    end

    enable_host_model enable_host_model_i (.ref_clk(ref_clk), .enable_pin(enable_pin));

    boost_mode_sequencer #(.SHUTDOWN_CYC(SD), .PSM_CYC(PSM), .FB_CYC(FB)) boost_mode_sequencer_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .enable_pin(enable_pin),
        .feedback_sense_pin(feedback_sense_pin), .vin_ok(vin_ok),
        .vout_near_vin(vout_near_vin), .vout_at_target(vout_at_target),
        .vout_below_save(vout_below_save), .light_load(light_load),
        .loop_current_trip(loop_current_trip), .peak_limit_trip(peak_limit_trip),
        .switch_node(switch_node), .fb_source_en(fb_source_en), .ext_divider(ext_divider),
        .linear_charge(linear_charge), .bias_en(bias_en), .limit_sel(limit_sel),
        .op_state(op_state)
    );

    // Level zero and the wrap after the fourth edge both show the minimum limit
    function automatic logic [2:0] exp_limit(input int n);
        return (n % 4 == 0) ? 3'h1 : 3'(n % 4);
    endfunction

    task automatic check3(input string name, input logic [2:0] exp, input logic [2:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask

    task automatic check_cnt(input string name, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", name, lo, hi, got);
        end
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask

    task automatic do_pulse(input bit shortest);
        int hi;
        int lo;
        hi = shortest ? 15 : 15 + int'($urandom % 186);
        lo = shortest ? 15 : 15 + int'($urandom % 21);
        enable_host_model_i.pulse(hi, lo);
        n_pulses++;
    endtask

    task automatic wait_state(input logic [2:0] s, input int maxc);
        int i;
        i = 0;
        while (op_state !== s && i < maxc) begin
            @(negedge ref_clk);
            i++;
        end
        check3("op_state", s, op_state);
    endtask

    // Sampling on the falling edge keeps counts clear of input updates
    task automatic count_rises(input int n, output int c);
        logic prev;
        c = 0;
        @(negedge ref_clk);
        prev = switch_node;
        repeat (n) begin
            @(negedge ref_clk);
            if (switch_node === 1'b1 && prev !== 1'b1) c++;
            prev = switch_node;
        end
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        seed_v = $urandom(32'h83e0);
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (10) @(negedge ref_clk);
        check3("limit_sel", 3'h1, {1'b0, limit_sel});
        check3("op_state", boost_seq_pkg::ST_OFF, op_state);
        for (int k = 0; k < 10; k++) begin
            do_pulse(k < 3);
            check3("limit_sel", exp_limit(n_pulses), {1'b0, limit_sel});
        end
        enable_host_model_i.hold_low(SD + 20);
        check3("op_state", boost_seq_pkg::ST_OFF, op_state);
        check3("limit_sel", 3'h1, {1'b0, limit_sel});
        n_pulses = 0;
        repeat (2) do_pulse(1'b0);
        check3("limit_sel", exp_limit(n_pulses), {1'b0, limit_sel});
        // Power-up with the feedback pin pulled high by an external divider
        feedback_sense_pin <= 1'b1;
        enable_host_model_i.hold_high();
        n_pulses++;
        @(posedge ref_clk);
        vin_ok <= 1'b1;
        wait_state(boost_seq_pkg::ST_LINEAR, 60);
        check3("ext_divider", 3'h1, {2'h0, ext_divider});
        check3("linear_charge", 3'h1, {2'h0, linear_charge});
        @(posedge ref_clk);
        vout_near_vin <= 1'b1;
        trip_kind = 1;
        wait_state(boost_seq_pkg::ST_SOFT, 20);
        @(negedge ref_clk);
        check3("limit_sel", 3'h1, {1'b0, limit_sel});
        count_rises(200, r);
        check_cnt("soft rises", 4, 6, r);
        @(posedge ref_clk);
        vout_at_target <= 1'b1;
        wait_state(boost_seq_pkg::ST_PWM, 20);
        repeat (10) @(negedge ref_clk);
        check3("limit_sel", exp_limit(n_pulses), {1'b0, limit_sel});
        count_rises(200, r);
        check_cnt("pwm rises", 19, 21, r);
        @(posedge ref_clk);
        trip_kind = 2;
        count_rises(200, r);
        check_cnt("limit rises", 19, 21, r);
        @(posedge ref_clk);
        light_load <= 1'b1;
        vout_below_save <= 1'b1;
        wait_state(boost_seq_pkg::ST_BURST, 20);
        repeat (12) @(negedge ref_clk);
        count_rises(40, r);
        check_cnt("burst idle rises", 0, 0, r);
        @(posedge ref_clk);
        vout_at_target <= 1'b0;
        count_rises(100, r);
        check_cnt("burst rises", 9, 11, r);
        @(posedge ref_clk);
        vout_at_target <= 1'b1;
        vout_below_save <= 1'b0;
        repeat (PSM - 4) @(negedge ref_clk);
        check3("op_state", boost_seq_pkg::ST_BURST, op_state);
        wait_state(boost_seq_pkg::ST_SAVE, 12);
        check3("bias_en", 3'h0, {2'h0, bias_en});
        @(posedge ref_clk);
        vout_below_save <= 1'b1;
        wait_state(boost_seq_pkg::ST_BURST, 10);
        @(posedge ref_clk);
        light_load <= 1'b0;
        wait_state(boost_seq_pkg::ST_PWM, 10);
        @(posedge ref_clk);
        vin_ok <= 1'b0;
        wait_state(boost_seq_pkg::ST_OFF, 10);
        // Second power-on with the feedback pin left low
        feedback_sense_pin <= 1'b0;
        vin_ok <= 1'b1;
        do_reset();
        wait_state(boost_seq_pkg::ST_FB_DETECT, 30);
        check3("fb_source_en", 3'h1, {2'h0, fb_source_en});
        r = 0;
        while (op_state === boost_seq_pkg::ST_FB_DETECT && r < 100) begin
            @(negedge ref_clk);
            r++;
        end
        check_cnt("probe cycles", FB - 1, FB + 1, r);
        check3("ext_divider", 3'h0, {2'h0, ext_divider});
        tally_and_finish();
    end
endmodule
`default_nettype wire
